// ### design/ccr_pkg.sv
// Shared constants and types for the processor flags register
package ccr_pkg;

  // ----------------------------------------------------------------
  // Widths and bit positions
  // ----------------------------------------------------------------
  localparam int FLAG_W = 8;
  localparam int ALU_W = 32;
  localparam int MASK_POS = 7;
  localparam int USER6_POS = 6;
  localparam int HALF_POS = 5;
  localparam int USER4_POS = 4;
  localparam int NEG_POS = 3;
  localparam int ZERO_POS = 2;
  localparam int OVF_POS = 1;
  localparam int CARRY_POS = 0;

  // Sign bit and half-carry source bit per operand width
  localparam int BYTE_MSB = 7;
  localparam int WORD_MSB = 15;
  localparam int LONG_MSB = 31;
  localparam int BYTE_HALF = 3;
  localparam int WORD_HALF = 11;
  localparam int LONG_HALF = 27;
  localparam logic [ALU_W-1:0] BYTE_MASK = 32'h0000_00ff;
  localparam logic [ALU_W-1:0] WORD_MASK = 32'h0000_ffff;
  localparam logic [ALU_W-1:0] LONG_MASK = 32'hffff_ffff;

  // Only the mask bit has a defined value after reset; the rest start
  // at zero here although software must not rely on that.
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h80;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mask;
    logic user6;
    logic half;
    logic user4;
    logic neg;
    logic zero;
    logic ovf;
    logic carry;
  } flag_set_t;

  typedef enum logic [1:0] {
    W_BYTE = 2'h0,
    W_WORD = 2'h1,
    W_LONG = 2'h2
  } op_width_t;

  typedef enum logic [2:0] {
    OP_ADD = 3'h0,
    OP_ADDC = 3'h1,
    OP_SUB = 3'h2,
    OP_SUBC = 3'h3,
    OP_CMP = 3'h4,
    OP_NEG = 3'h5,
    OP_PASS = 3'h6
  } alu_op_t;

  typedef struct packed {
    alu_op_t op;
    op_width_t width;
    logic [ALU_W-1:0] a;
    logic [ALU_W-1:0] b;
    logic [ALU_W-1:0] ext;
    logic extCarry;
  } alu_req_t;

  typedef enum logic [2:0] {
    CTL_NONE = 3'h0,
    CTL_LOAD = 3'h1,
    CTL_AND = 3'h2,
    CTL_OR = 3'h3,
    CTL_XOR = 3'h4
  } flag_ctl_kind_t;

  typedef struct packed {
    flag_ctl_kind_t kind;
    logic [FLAG_W-1:0] data;
  } flag_ctl_t;

  typedef enum logic [3:0] {
    BC_ALWAYS = 4'h0,
    BC_NEVER = 4'h1,
    BC_HI = 4'h2,
    BC_LS = 4'h3,
    BC_CC = 4'h4,
    BC_CS = 4'h5,
    BC_NE = 4'h6,
    BC_EQ = 4'h7,
    BC_VC = 4'h8,
    BC_VS = 4'h9,
    BC_PL = 4'ha,
    BC_MI = 4'hb,
    BC_GE = 4'hc,
    BC_LT = 4'hd,
    BC_GT = 4'he,
    BC_LE = 4'hf
  } branch_cond_t;

endpackage

// ### design/flag_eval.sv
// Combinational flag evaluation for add, subtract, compare and negate
`timescale 1ns/1ps
module flag_eval import ccr_pkg::*; (
  input wire alu_req_t req,
  output flag_set_t flags,
  output logic [ALU_W-1:0] result
);

  logic [ALU_W:0] x;
  logic [ALU_W:0] y;
  logic [ALU_W:0] s;
  logic [ALU_W-1:0] wmask;
  logic subOp;
  logic arith;
  logic cin;
  int unsigned msb;
  int unsigned hb;

  always_comb begin
    case (req.width)
      W_BYTE: begin
        msb = BYTE_MSB;
        hb = BYTE_HALF + 1;
        wmask = BYTE_MASK;
      end
      W_WORD: begin
        msb = WORD_MSB;
        hb = WORD_HALF + 1;
        wmask = WORD_MASK;
      end
      default: begin
        msb = LONG_MSB;
        hb = LONG_HALF + 1;
        wmask = LONG_MASK;
      end
    endcase
    x = {1'b0, req.a & wmask};
    y = {1'b0, req.b & wmask};
    subOp = 1'b0;
    arith = 1'b1;
    cin = 1'b0;
    case (req.op)
      OP_ADD: subOp = 1'b0;
      OP_ADDC: cin = req.extCarry;
      OP_SUB, OP_CMP: subOp = 1'b1;
      OP_SUBC: begin
        subOp = 1'b1;
        cin = req.extCarry;
      end
      OP_NEG: begin
        subOp = 1'b1;
        x = '0;
        y = {1'b0, req.a & wmask};
      end
      default: arith = 1'b0;
    endcase
    // Operands are width-masked, so a carry or borrow lands on msb+1
    if (subOp) begin
      s = x - y - {{ALU_W{1'b0}}, cin};
    end else begin
      s = x + y + {{ALU_W{1'b0}}, cin};
    end
    result = arith ? (s[ALU_W-1:0] & wmask) : (req.ext & wmask);
    flags = '0;
    flags.neg = result[msb];
    flags.zero = (result == '0);
    if (arith) begin
      flags.carry = s[msb+1];
      // Carry into hb equals carry out of the half bit
      flags.half = x[hb] ^ y[hb] ^ s[hb];
      if (subOp) begin
        flags.ovf = (x[msb] != y[msb]) && (s[msb] != x[msb]);
      end else begin
        flags.ovf = (x[msb] == y[msb]) && (s[msb] != x[msb]);
      end
    end else begin
      flags.carry = req.extCarry;
    end
  end

endmodule

// ### design/condition_code_register.sv
// Processor condition flags register with update, branch and mask logic
`timescale 1ns/1ps

// Notes on behaviour
// - Eight-bit register, fixed bit layout
// - Bit 0 carry from add, sub, shift
// - Carry doubles as bit accumulator
// - Reset forces mask bit to one
// - Mask bit blocks all maskable interrupts
// - Non-maskable interrupt always accepted
// - Exception start sets mask bit
// - Per-instruction write mask keeps flags
// - Load, store, and, or, xor whole register
// - User bits are plain storage only; an ALU update whose writeMask selects them clears them
// - Branches use negative, zero, overflow, carry
// - Byte half-carry from bit three
// - Word half-carry from bit eleven
// - Long half-carry from bit twenty-seven
// - Negative copies result sign bit
// - Zero set when result all zero
// - Overflow set on signed range overflow
module condition_code_register import ccr_pkg::*; #(
  parameter int DATA_W = ALU_W
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic aluUpdate,
  input wire alu_req_t aluReq,
  input wire logic [FLAG_W-1:0] writeMask,
  input wire flag_ctl_t flagCtl,
  input wire logic bitAccWe,
  input wire logic bitAccIn,
  input wire logic excStart,
  input wire logic irqPending,
  input wire logic nmiPending,
  input wire branch_cond_t branchCond,
  output flag_set_t condition_flags,
  output logic [DATA_W-1:0] aluResult,
  output logic bitAcc,
  output logic branchTaken,
  output logic irqAccept,
  output logic nmiAccept
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != ALU_W) begin : g_width_check
    $error("DATA_W must equal the longword width");
  end

  // ----------------------------------------------------------------
  // Flag evaluation
  // ----------------------------------------------------------------
  flag_set_t evalFlags;
  logic [ALU_W-1:0] evalResult;

  flag_eval u_eval (
    .req(aluReq),
    .flags(evalFlags),
    .result(evalResult)
  );

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  flag_set_t flags_q;
  flag_set_t flags_d;
  logic [ALU_W-1:0] result_q;
  logic [ALU_W-1:0] result_d;

  always_comb begin
    flags_d = flags_q;
    result_d = result_q;
    if (aluUpdate) begin
      // Bits outside the mask keep their old value
      flags_d = (flags_q & ~writeMask) | (evalFlags & writeMask);
      result_d = evalResult;
    end
    if (bitAccWe) begin
      flags_d.carry = bitAccIn;
    end
    // Explicit access last so it overrides implicit updates
    case (flagCtl.kind)
      CTL_LOAD: flags_d = flagCtl.data;
      CTL_AND: flags_d = flags_q & flagCtl.data;
      CTL_OR: flags_d = flags_q | flagCtl.data;
      CTL_XOR: flags_d = flags_q ^ flagCtl.data;
      default: flags_d = flags_d;
    endcase
    // Exception entry outranks everything for the mask bit
    if (excStart) begin
      flags_d.mask = 1'b1;
    end
  end

  // User bits are touched by the explicit paths above, or cleared by an ALU update whose writeMask selects them
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= FLAGS_RESET;
      result_q <= '0;
    end else begin
      flags_q <= flags_d;
      result_q <= result_d;
    end
  end

  // Store path reads the register directly
  assign condition_flags = flags_q;
  assign aluResult = result_q;
  assign bitAcc = flags_q.carry;

  // ----------------------------------------------------------------
  // Interrupt acceptance
  // ----------------------------------------------------------------
  assign irqAccept = irqPending && !flags_q.mask;
  assign nmiAccept = nmiPending;

  // ----------------------------------------------------------------
  // Branch evaluation
  // ----------------------------------------------------------------
  logic nXorV;

  always_comb begin
    nXorV = flags_q.neg ^ flags_q.ovf;
    case (branchCond)
      BC_ALWAYS: branchTaken = 1'b1;
      BC_NEVER: branchTaken = 1'b0;
      BC_HI: branchTaken = !(flags_q.carry || flags_q.zero);
      BC_LS: branchTaken = flags_q.carry || flags_q.zero;
      BC_CC: branchTaken = !flags_q.carry;
      BC_CS: branchTaken = flags_q.carry;
      BC_NE: branchTaken = !flags_q.zero;
      BC_EQ: branchTaken = flags_q.zero;
      BC_VC: branchTaken = !flags_q.ovf;
      BC_VS: branchTaken = flags_q.ovf;
      BC_PL: branchTaken = !flags_q.neg;
      BC_MI: branchTaken = flags_q.neg;
      BC_GE: branchTaken = !nXorV;
      BC_LT: branchTaken = nXorV;
      BC_GT: branchTaken = !(flags_q.zero || nXorV);
      BC_LE: branchTaken = flags_q.zero || nXorV;
      default: branchTaken = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic afterReset_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      afterReset_q <= 1'b0;
    end else begin
      afterReset_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  logic plainAlu;
  assign plainAlu = aluUpdate && (flagCtl.kind == CTL_NONE) && !bitAccWe
    && !excStart;

  resetMask_a: assert property (
    !afterReset_q |-> flags_q.mask)
    else $error("mask bit not set after reset");

  irqBlocked_a: assert property (
    flags_q.mask |-> !irqAccept)
    else $error("maskable interrupt accepted while masked");

  nmiAccepted_a: assert property (
    nmiPending |-> nmiAccept)
    else $error("non-maskable interrupt refused");

  excSetsMask_a: assert property (
    excStart |=> flags_q.mask && !irqAccept)
    else $error("exception entry left mask bit clear");

  keepFlags_a: assert property (
    plainAlu |=> ((flags_q & ~$past(writeMask))
      == ($past(flags_q) & ~$past(writeMask))))
    else $error("unselected flag changed on update");

  loadWrite_a: assert property (
    (flagCtl.kind == CTL_LOAD) && !excStart
      |=> flags_q == $past(flagCtl.data))
    else $error("load did not write whole register");

  explicitWins_a: assert property (
    (flagCtl.kind == CTL_XOR) && aluUpdate && !excStart
      |=> flags_q == ($past(flags_q) ^ $past(flagCtl.data)))
    else $error("implicit update overrode explicit write");

  bitAccum_a: assert property (
    bitAccWe && (flagCtl.kind == CTL_NONE) |=> bitAcc == $past(bitAccIn))
    else $error("bit accumulator write lost");

  zeroFlag_a: assert property (
    plainAlu && writeMask[ZERO_POS]
      |=> flags_q.zero == (aluResult == '0))
    else $error("zero flag disagrees with result");

  byteHalf_a: assert property (
    plainAlu && writeMask[HALF_POS] && (aluReq.op == OP_ADD)
      && (aluReq.width == W_BYTE)
      |=> flags_q.half == (($past(aluReq.a[3:0]) + $past(aluReq.b[3:0]))
        > 5'h0f))
    else $error("byte half-carry wrong");

  signFlag_a: assert property (
    plainAlu && writeMask[NEG_POS] && (aluReq.width == W_WORD)
      |=> flags_q.neg == aluResult[WORD_MSB])
    else $error("negative flag not word sign bit");

  branchEq_a: assert property (
    (branchCond == BC_EQ) |-> branchTaken == flags_q.zero)
    else $error("equal branch ignores zero flag");

  excCov_c: cover property (excStart ##1 irqPending && !irqAccept);
  loadCov_c: cover property ((flagCtl.kind == CTL_LOAD) && aluUpdate);
  carryCov_c: cover property (plainAlu ##1 flags_q.carry);
  nmiCov_c: cover property (nmiPending && flags_q.mask);

endmodule

// ### test/cpu_seq_model.sv
// Instruction sequencer model that drives the flags register inputs
`timescale 1ns/1ps
module cpu_seq_model import ccr_pkg::*; (
  input wire logic clock,
  output logic aluUpdate,
  output alu_req_t aluReq,
  output logic [FLAG_W-1:0] writeMask,
  output flag_ctl_t flagCtl,
  output logic bitAccWe,
  output logic bitAccIn,
  output logic excStart
);
  // ----------------------------------------------------------------
  // One instruction per call
  // ----------------------------------------------------------------
  initial begin
    aluUpdate = 1'b0;
    aluReq = '0;
    writeMask = '0;
    flagCtl = '0;
    bitAccWe = 1'b0;
    bitAccIn = 1'b0;
    excStart = 1'b0;
  end

  // Strobes last exactly one cycle, launched and dropped off the edge
  task automatic issue(input logic upd, input alu_op_t op,
      input op_width_t w, input logic [ALU_W-1:0] a, b,
      input logic cin, input logic [FLAG_W-1:0] m,
      input flag_ctl_kind_t k, input logic [FLAG_W-1:0] d,
      input logic bw, input logic ex);
    @(negedge clock);
    aluUpdate = upd;
    aluReq = '{op: op, width: w, a: a, b: b, ext: '0, extCarry: cin};
    writeMask = m;
    flagCtl = '{kind: k, data: d};
    bitAccWe = bw;
    bitAccIn = bw;
    excStart = ex;
    @(negedge clock);
    aluUpdate = 1'b0;
    flagCtl.kind = CTL_NONE;
    bitAccWe = 1'b0;
    excStart = 1'b0;
  endtask
endmodule

// ### test/condition_code_register_bench.sv
// Self-checking bench for the processor flags register
`timescale 1ns/1ps
module condition_code_register_bench;
  import ccr_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic irqPending = 1'b1;
  logic nmiPending = 1'b1;
  branch_cond_t branchCond = BC_ALWAYS;
  logic aluUpdate, bitAccWe, bitAccIn, excStart;
  logic bitAcc, branchTaken, irqAccept, nmiAccept;
  alu_req_t aluReq;
  logic [FLAG_W-1:0] writeMask;
  flag_ctl_t flagCtl;
  flag_set_t condition_flags;
  logic [ALU_W-1:0] aluResult;
  int fail_count = 0;
  int n_checks = 0;

  always #4 clock = ~clock;

  cpu_seq_model partner_u (.clock, .aluUpdate, .aluReq, .writeMask,
    .flagCtl, .bitAccWe, .bitAccIn, .excStart);

  condition_code_register dut_u (.clock, .arst_n, .aluUpdate, .aluReq,
    .writeMask, .flagCtl, .bitAccWe, .bitAccIn, .excStart, .irqPending,
    .nmiPending, .branchCond, .condition_flags, .aluResult, .bitAcc,
    .branchTaken, .irqAccept, .nmiAccept);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Mask 8'h2f commits half, negative, zero, overflow and carry only
  task automatic alu(input alu_op_t op, input op_width_t w,
      input logic [31:0] a, b, input logic cin, input logic [7:0] m,
      input logic [7:0] expF, input logic [31:0] expR);
    partner_u.issue(1'b1, op, w, a, b, cin, m, CTL_NONE, 8'h00, 1'b0, 1'b0);
    check("flags", condition_flags, expF);
    if (m != 8'h00) begin
      check("result", aluResult, expR);
    end
  endtask

  task automatic ctl(input flag_ctl_kind_t k, input logic [7:0] d,
      input logic [7:0] expF);
    partner_u.issue(1'b0, OP_ADD, W_BYTE, '0, '0, 1'b0, 8'h00, k, d, 1'b0,
      1'b0);
    check("flags", condition_flags, expF);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (10) @(negedge clock);
    check("reset mask", condition_flags.mask, 1'b1);
    check("irq masked", irqAccept, 1'b0);
    check("nmi", nmiAccept, 1'b1);
    arst_n = 1'b1;
  endtask

  task automatic t_arith();
    alu(OP_ADD, W_BYTE, 32'h08, 32'h08, 1'b0, 8'h2f, 8'ha0,
      32'h10);
    alu(OP_ADD, W_BYTE, 32'h7f, 32'h01, 1'b0, 8'h2f, 8'haa,
      32'h80);
    alu(OP_ADD, W_BYTE, 32'hff, 32'h01, 1'b0, 8'h2f, 8'ha5,
      32'h00);
    alu(OP_SUB, W_BYTE, 32'h10, 32'h01, 1'b0, 8'h2f, 8'ha0,
      32'h0f);
    alu(OP_NEG, W_BYTE, 32'h01, 32'h00, 1'b0, 8'h2f, 8'ha9,
      32'hff);
    alu(OP_ADD, W_WORD, 32'h0800, 32'h0800, 1'b0, 8'h2f, 8'ha0,
      32'h1000);
    alu(OP_ADD, W_WORD, 32'hffff, 32'h1, 1'b0, 8'h2f, 8'ha5,
      32'h0);
    alu(OP_ADD, W_LONG, 32'h0800_0000, 32'h0800_0000, 1'b0, 8'h2f, 8'ha0,
      32'h1000_0000);
    alu(OP_ADD, W_LONG, 32'h7fff_ffff, 32'h1, 1'b0, 8'h2f, 8'haa,
      32'h8000_0000);
    alu(OP_ADDC, W_BYTE, 32'h0f, 32'h00, 1'b1, 8'h2f, 8'ha0,
      32'h10);
    alu(OP_ADD, W_BYTE, 32'hff, 32'h01, 1'b0, 8'h00, 8'ha0,
      32'h0);
    // Shift carry arrives through the pass path
    alu(OP_PASS, W_BYTE, 32'h0, 32'h0, 1'b1, 8'h2f, 8'h85,
      32'h0);
    alu(OP_SUBC, W_BYTE, 32'h10, 32'h0f, 1'b1, 8'h2f, 8'ha4,
      32'h0);
    alu(OP_CMP, W_BYTE, 32'h01, 32'h02, 1'b0, 8'h2f, 8'ha9,
      32'hff);
  endtask

  task automatic t_ctl();
    ctl(CTL_LOAD, 8'h55, 8'h55);
    check("irq open", irqAccept, 1'b1);
    ctl(CTL_AND, 8'h0f, 8'h05);
    ctl(CTL_OR, 8'hd0, 8'hd5);
    ctl(CTL_XOR, 8'hff, 8'h2a);
    partner_u.issue(1'b0, OP_ADD, W_BYTE, '0, '0, 1'b0, 8'h00, CTL_NONE,
      8'h00, 1'b1, 1'b0);
    check("bit acc", {condition_flags, bitAcc}, 9'h057);
  endtask

  task automatic t_priority();
    partner_u.issue(1'b1, OP_ADD, W_BYTE, 32'hff, 32'h01, 1'b0, 8'h2f,
      CTL_LOAD, 8'h04, 1'b0, 1'b0);
    check("explicit wins", condition_flags, 8'h04);
    branchCond = BC_EQ;
    #1 check("eq", branchTaken, 1'b1);
    branchCond = BC_NE;
    #1 check("ne", branchTaken, 1'b0);
    ctl(CTL_LOAD, 8'h09, 8'h09);
    branchCond = BC_CS;
    #1 check("cs", branchTaken, 1'b1);
    branchCond = BC_PL;
    #1 check("pl", branchTaken, 1'b0);
    partner_u.issue(1'b0, OP_ADD, W_BYTE, '0, '0, 1'b0, 8'h00, CTL_NONE,
      8'h00, 1'b0, 1'b1);
    check("exception", condition_flags, 8'h89);
    check("irq after exc", irqAccept, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    t_reset();
    t_arith();
    t_ctl();
    t_priority();
    final_report();
  end

  initial begin
    #100000;
    fail_count++;
    final_report();
  end
endmodule
